/* logic/pfc_pkg.sv */
// Shared constants and carrier types for the parallel flash command controller.
package pfc_pkg;
   // Clock rate used to turn times into cycle counts.
   localparam int CLK_MHZ = 20;
   // Bus timing in nanoseconds and microseconds, and derived cycle counts (rounded up).
   localparam int T_WE_LOW_NS = 100;
   localparam int T_WE_HIGH_NS = 50;
   localparam int T_ACCESS_NS = 100;
   localparam int T_RESET_LOW_NS = 500;
   localparam int T_MAX_READY_US = 20;
   localparam int WE_LOW_CYC = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int WE_HIGH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
   localparam int RESET_LOW_CYC = (T_RESET_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int MAX_READY_CYC = T_MAX_READY_US * CLK_MHZ;
   // Data bus pins pass two synchroniser stages before being sampled.
   localparam int SYNC_CYC = 2;
   // Register offsets on the software port.
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   // Status register field positions.
   localparam int ST_BUSY = 0;
   localparam int ST_FAIL = 1;
   localparam int ST_READY = 2;
   localparam int ST_ID_MODE = 3;
   localparam int ST_RDATA_LSB = 8;
   // Status bit positions on the flash data bus.
   localparam int DATA_POLL_BIT = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int TIME_EXCEEDED_BIT = 5;
   // Command bytes written to the flash.
   localparam logic [7:0] CB_UNLOCK1 = 8'hAA;
   localparam logic [7:0] CB_UNLOCK2 = 8'h55;
   localparam logic [7:0] CB_AUTOSEL = 8'h90;
   localparam logic [7:0] CB_PROGRAM = 8'hA0;
   localparam logic [7:0] CB_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CB_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CB_RESET = 8'hF0;
   localparam logic [7:0] CB_QUERY = 8'h98;
   localparam logic [7:0] CB_SUSPEND = 8'hB0;
   localparam logic [7:0] CB_RESUME = 8'h30;
   // Unlock addresses; the flash accepts any address for these cycles.
   localparam logic [21:0] UNLOCK_ADDR1 = 22'h000555;
   localparam logic [21:0] UNLOCK_ADDR2 = 22'h0002AA;
   // Reset values.
   localparam logic [21:0] ADDR_RESET = 22'h000000;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Operations software can order through the command register.
   typedef enum logic [3:0] {
      OP_READ = 4'h0,
      OP_PROGRAM = 4'h1,
      OP_CHIP_ERASE = 4'h2,
      OP_RESET = 4'h3,
      OP_AUTOSEL = 4'h4,
      OP_QUERY = 4'h5,
      OP_SUSPEND = 4'h6,
      OP_RESUME = 4'h7,
      OP_HW_RESET = 4'h8
   } pfc_op_t;
   // Flash pin bundle driven by the controller.
   typedef struct packed {
      logic [21:0] addr;
      logic [7:0] dq;
      logic dq_oe;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic reset_n;
   } pfc_pins_t;
   // One bus write cycle of a command sequence.
   typedef struct packed {
      logic [21:0] addr;
      logic [7:0] data;
   } pfc_cycle_t;
endpackage

/* logic/pfc_ctrl.sv */
// Host-side controller that drives a parallel NOR flash through its pins.
// What this block does
// - Autoselect: AA, 55, 90, then plain reads.
// - Program: AA, 55, A0, then address/data.
// - Chip erase: AA,55,80,AA,55,10 exactly.
// - Reset F0, query 98, suspend B0, resume 30.
// - After time exceeded, host writes reset command.
// - Only the reset command or a hardware reset leaves autoselect mode.
`timescale 1ns/1ns
`default_nettype none
module pfc_ctrl
   import pfc_pkg::*;
#(
   parameter int READY_WAIT_CYC = MAX_READY_CYC
) (
   input wire logic CLK,
   input wire logic NRST,
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   output logic [21:0] FL_ADDR,
   input wire logic [7:0] FL_DQ_I,
   output logic [7:0] FL_DQ_O,
   output logic FL_DQ_OE,
   output logic FL_CE_N,
   output logic FL_WE_N,
   output logic FL_OE_N,
   output logic FL_RESET_N,
   input wire logic FL_READY_BUSY_N
);
   // The wait counter is 16 bits wide and must count at least one cycle.
   if (READY_WAIT_CYC < 1 || READY_WAIT_CYC > 65535) begin : g_bad_wait
      $error("READY_WAIT_CYC out of range");
   end

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_SETUP = 3'b001,
      S_WE_LOW = 3'b011,
      S_WE_HIGH = 3'b010,
      S_RD_LOW = 3'b110,
      S_RD_DONE = 3'b111,
      S_RST_LOW = 3'b101,
      S_RST_WAIT = 3'b100
   } pfc_state_t;

   // Reset release through two flip-flops.
   logic [1:0] rst_sync_q;
   logic rst_n;
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Pin inputs cross from the flash's asynchronous world through two stages.
   logic [8:0] pin_meta_q;
   logic [8:0] pin_sync_q;
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta_q <= 9'h1FF;
         pin_sync_q <= 9'h1FF;
      end else begin
         pin_meta_q <= {FL_READY_BUSY_N, FL_DQ_I};
         pin_sync_q <= pin_meta_q;
      end
   end

   // Number of bus writes in each operation's command sequence.
   function automatic logic [2:0] seq_len(input pfc_op_t op);
      unique case (op)
         OP_PROGRAM: seq_len = 3'h4;
         OP_CHIP_ERASE: seq_len = 3'h6;
         OP_AUTOSEL: seq_len = 3'h3;
         default: seq_len = 3'h1;
      endcase
   endfunction

   // Address and data of write number idx in the sequence of op.
   function automatic pfc_cycle_t seq_step(input pfc_op_t op, input logic [2:0] idx,
                                           input logic [21:0] a, input logic [7:0] d);
      pfc_cycle_t c;
      c = '{addr: UNLOCK_ADDR1, data: CB_RESET};
      if (idx == 3'h0 || idx == 3'h3) begin
         c.data = CB_UNLOCK1;
      end else if (idx == 3'h1 || idx == 3'h4) begin
         c = '{addr: UNLOCK_ADDR2, data: CB_UNLOCK2};
      end
      unique case (op)
         OP_PROGRAM: begin
            if (idx == 3'h2) c.data = CB_PROGRAM;
            if (idx == 3'h3) c = '{addr: a, data: d};
         end
         OP_CHIP_ERASE: begin
            if (idx == 3'h2) c.data = CB_ERASE_SETUP;
            if (idx == 3'h5) c.data = CB_CHIP_ERASE;
         end
         OP_AUTOSEL: begin
            if (idx == 3'h2) c.data = CB_AUTOSEL;
         end
         OP_QUERY: c.data = CB_QUERY;
         OP_SUSPEND: c.data = CB_SUSPEND;
         OP_RESUME: c.data = CB_RESUME;
         default: c.data = CB_RESET;
      endcase
      return c;
   endfunction

   pfc_state_t state_q, state_d;
   pfc_op_t op_q, op_d;
   pfc_pins_t pins_q, pins_d;
   logic [15:0] cnt_q, cnt_d;
   logic [2:0] idx_q, idx_d;
   logic [21:0] addr_q, addr_d;
   logic [7:0] data_q, data_d;
   logic [7:0] rbyte_q, rbyte_d;
   logic polling_q, polling_d;
   logic have_prev_q, have_prev_d;
   logic recheck_q, recheck_d;
   logic fail_q, fail_d;
   logic id_mode_q, id_mode_d;
   logic [31:0] rdata_q, rdata_d;
   logic cmd_wr;
   pfc_cycle_t step;
   logic [7:0] dq_now;

   assign cmd_wr = REG_WR && REG_ADDR == REG_CMD;
   assign step = seq_step(op_q, idx_q, addr_q, data_q);
   assign dq_now = pin_sync_q[7:0];

   // Sequencer, software registers and pin drive; all pins leave from pins_q.
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      pins_d = pins_q;
      cnt_d = cnt_q;
      idx_d = idx_q;
      addr_d = addr_q;
      data_d = data_q;
      rbyte_d = rbyte_q;
      polling_d = polling_q;
      have_prev_d = have_prev_q;
      recheck_d = recheck_q;
      fail_d = fail_q;
      id_mode_d = id_mode_q;
      // The port shares its name with the offset, so the offset is named through the package.
      if (REG_WR && REG_ADDR == pfc_pkg::REG_ADDR && state_q == S_IDLE) begin
         addr_d = REG_WDATA[21:0];
      end
      if (REG_WR && REG_ADDR == REG_DATA && state_q == S_IDLE) data_d = REG_WDATA[7:0];
      unique case (state_q)
         S_IDLE: begin
            // New orders are refused while busy, so the flash never sees writes mid-operation.
            if (cmd_wr) begin
               op_d = pfc_op_t'(REG_WDATA[3:0]);
               idx_d = 3'h0;
               cnt_d = 16'(RESET_LOW_CYC);
               if (REG_WDATA[3:0] == OP_HW_RESET) begin
                  pins_d.reset_n = 1'b0;
                  state_d = S_RST_LOW;
               end else if (REG_WDATA[3:0] == OP_READ) begin
                  pins_d.addr = addr_q;
                  pins_d.ce_n = 1'b0;
                  pins_d.oe_n = 1'b0;
                  polling_d = 1'b0;
                  cnt_d = 16'(ACCESS_CYC + SYNC_CYC);
                  state_d = S_RD_LOW;
               end else if (REG_WDATA[3:0] <= OP_RESUME) begin
                  fail_d = 1'b0;
                  state_d = S_SETUP;
               end
            end
         end
         S_SETUP: begin
            pins_d.addr = step.addr;
            pins_d.dq = step.data;
            pins_d.dq_oe = 1'b1;
            pins_d.ce_n = 1'b0;
            pins_d.we_n = 1'b0;
            cnt_d = 16'(WE_LOW_CYC);
            state_d = S_WE_LOW;
         end
         S_WE_LOW: begin
            cnt_d = cnt_q - 16'h1;
            if (cnt_q == 16'h1) begin
               pins_d.we_n = 1'b1;
               cnt_d = 16'(WE_HIGH_CYC);
               state_d = S_WE_HIGH;
            end
         end
         S_WE_HIGH: begin
            cnt_d = cnt_q - 16'h1;
            if (cnt_q == 16'h1) begin
               pins_d.ce_n = 1'b1;
               pins_d.dq_oe = 1'b0;
               idx_d = idx_q + 3'h1;
               if (idx_q + 3'h1 < seq_len(op_q)) begin
                  state_d = S_SETUP;
               end else if (op_q == OP_PROGRAM || op_q == OP_CHIP_ERASE) begin
                  // Status polling reads any address inside the target.
                  polling_d = 1'b1;
                  have_prev_d = 1'b0;
                  recheck_d = 1'b0;
                  pins_d.ce_n = 1'b0;
                  pins_d.oe_n = 1'b0;
                  cnt_d = 16'(ACCESS_CYC + SYNC_CYC);
                  state_d = S_RD_LOW;
               end else begin
                  if (op_q == OP_AUTOSEL || op_q == OP_QUERY) id_mode_d = 1'b1;
                  if (op_q == OP_RESET) id_mode_d = 1'b0;
                  state_d = S_IDLE;
               end
            end
         end
         S_RD_LOW: begin
            cnt_d = cnt_q - 16'h1;
            if (cnt_q == 16'h1) begin
               pins_d.ce_n = 1'b1;
               pins_d.oe_n = 1'b1;
               rbyte_d = dq_now;
               have_prev_d = polling_q;
               state_d = S_RD_DONE;
            end
         end
         S_RD_DONE: begin
            state_d = S_IDLE;
            // Each status read is a fresh strobe, so the toggle bit moves between reads.
            if (polling_q) begin
               state_d = S_RD_LOW;
               pins_d.ce_n = 1'b0;
               pins_d.oe_n = 1'b0;
               cnt_d = 16'(ACCESS_CYC + SYNC_CYC);
            end
         end
         S_RST_LOW: begin
            cnt_d = cnt_q - 16'h1;
            if (cnt_q == 16'h1) begin
               pins_d.reset_n = 1'b1;
               cnt_d = 16'(READY_WAIT_CYC);
               state_d = S_RST_WAIT;
            end
         end
         S_RST_WAIT: begin
            // The flash may need the full ready time to abandon a running operation.
            cnt_d = cnt_q - 16'h1;
            if (cnt_q == 16'h1) begin
               id_mode_d = 1'b0;
               polling_d = 1'b0;
               state_d = S_IDLE;
            end
         end
      endcase
      // Toggle comparison: a stopped toggle ends the operation, a stuck timeout is a failure.
      if (state_q == S_RD_LOW && cnt_q == 16'h1 && polling_q && have_prev_q) begin
         if (dq_now[TOGGLE_BIT] == rbyte_q[TOGGLE_BIT]) begin
            polling_d = 1'b0;
            have_prev_d = 1'b0;
            state_d = S_IDLE;
         end else if (dq_now[TIME_EXCEEDED_BIT] && recheck_q) begin
            // Failure leaves the flash out of array read until it sees the reset command.
            fail_d = 1'b1;
            polling_d = 1'b0;
            op_d = OP_RESET;
            idx_d = 3'h0;
            state_d = S_SETUP;
         end else begin
            recheck_d = dq_now[TIME_EXCEEDED_BIT];
         end
      end else if (state_q == S_RD_LOW && cnt_q == 16'h1 && polling_q) begin
         have_prev_d = 1'b1;
      end
   end

   // Register read port: data appears in the cycle after the strobe only.
   always_comb begin
      rdata_d = 32'h0;
      if (REG_RD) begin
         unique case (REG_ADDR)
            pfc_pkg::REG_ADDR: rdata_d = {10'h0, addr_q};
            REG_DATA: rdata_d = {24'h0, data_q};
            REG_STATUS: begin
               rdata_d[ST_BUSY] = state_q != S_IDLE;
               rdata_d[ST_FAIL] = fail_q;
               rdata_d[ST_READY] = pin_sync_q[8];
               rdata_d[ST_ID_MODE] = id_mode_q;
               rdata_d[ST_RDATA_LSB +: 8] = rbyte_q;
            end
            default: rdata_d = 32'h0;
         endcase
      end
   end

   // State registers.
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_IDLE;
         op_q <= OP_READ;
         pins_q <= '{addr: ADDR_RESET, dq: DATA_RESET, dq_oe: 1'b0, ce_n: 1'b1,
                     we_n: 1'b1, oe_n: 1'b1, reset_n: 1'b1};
         cnt_q <= 16'h0;
         idx_q <= 3'h0;
         addr_q <= ADDR_RESET;
         data_q <= DATA_RESET;
         rbyte_q <= DATA_RESET;
         polling_q <= 1'b0;
         have_prev_q <= 1'b0;
         recheck_q <= 1'b0;
         fail_q <= 1'b0;
         id_mode_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         pins_q <= pins_d;
         cnt_q <= cnt_d;
         idx_q <= idx_d;
         addr_q <= addr_d;
         data_q <= data_d;
         rbyte_q <= rbyte_d;
         polling_q <= polling_d;
         have_prev_q <= have_prev_d;
         recheck_q <= recheck_d;
         fail_q <= fail_d;
         id_mode_q <= id_mode_d;
         rdata_q <= rdata_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign FL_ADDR = pins_q.addr;
   assign FL_DQ_O = pins_q.dq;
   assign FL_DQ_OE = pins_q.dq_oe;
   assign FL_CE_N = pins_q.ce_n;
   assign FL_WE_N = pins_q.we_n;
   assign FL_OE_N = pins_q.oe_n;
   assign FL_RESET_N = pins_q.reset_n;
endmodule
`default_nettype wire

/* test/pfc_ctrl_properties.sv */
// Concurrent checks on the flash controller pins and register port.
`timescale 1ns/1ns
`default_nettype none
module pfc_ctrl_properties
   import pfc_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic REG_RD,
   input wire logic [31:0] REG_RDATA,
   input wire logic [21:0] FL_ADDR,
   input wire logic [7:0] FL_DQ_O,
   input wire logic FL_DQ_OE,
   input wire logic FL_CE_N,
   input wire logic FL_WE_N,
   input wire logic FL_OE_N,
   input wire logic FL_RESET_N
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   // Read data may only appear in the slot after a read strobe.
   property p_rdata_slot; REG_RDATA != 32'h0 |-> $past(REG_RD); endproperty
   a_rdata_slot: assert property (p_rdata_slot)
      else $error("Read data outside its slot.");
   // A write pulse is only valid with the chip selected and outputs off.
   property p_we_ce; !FL_WE_N |-> !FL_CE_N && FL_OE_N; endproperty
   a_we_ce: assert property (p_we_ce)
      else $error("Write pulse without chip select or with output enable.");
   property p_we_drive; !FL_WE_N |-> FL_DQ_OE; endproperty
   a_we_drive: assert property (p_we_drive)
      else $error("Write pulse without driven data.");
   // Driving the bus while the flash drives it would clash.
   property p_read_nodrive; !FL_OE_N |-> !FL_DQ_OE && !FL_CE_N; endproperty
   a_read_nodrive: assert property (p_read_nodrive)
      else $error("Data driven during a read.");
   property p_we_len; $fell(FL_WE_N) |-> !FL_WE_N ##1 !FL_WE_N ##1 FL_WE_N; endproperty
   a_we_len: assert property (p_we_len)
      else $error("Write pulse length wrong.");
   // The flash latches at the rising write edge, so data must not move there.
   property p_latch; $rose(FL_WE_N) |-> $stable(FL_DQ_O) && $stable(FL_ADDR) && !FL_CE_N;
   endproperty
   a_latch: assert property (p_latch)
      else $error("Data moved at the latching edge.");
   property p_rst_len;
      $fell(FL_RESET_N) |-> !FL_RESET_N[*8] ##1 !FL_RESET_N ##1 !FL_RESET_N ##1 FL_RESET_N;
   endproperty
   a_rst_len: assert property (p_rst_len)
      else $error("Hardware reset pulse length wrong.");
   property p_rst_quiet; !FL_RESET_N |-> FL_WE_N && FL_OE_N; endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("Bus cycle during hardware reset.");
   cover property ($fell(FL_RESET_N));
   cover property ($fell(FL_WE_N) && FL_DQ_O == CB_CHIP_ERASE);
   cover property ($fell(FL_WE_N) && FL_DQ_O == CB_AUTOSEL);
endmodule
bind pfc_ctrl pfc_ctrl_properties u_props (.CLK(CLK), .NRST(NRST), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE),
   .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N), .FL_RESET_N(FL_RESET_N));
`default_nettype wire

/* test/pfc_flash_model.sv */
// Behavioural parallel flash: command decoder, 16-byte array, status polling.
`timescale 1ns/1ns
`default_nettype none
module pfc_flash_model #(
   parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value.
   parameter logic [7:0] DEV_ID = 8'h7E, // Arbitrary value.
   parameter int BUSY_NS = 3000
) (
   input wire logic [21:0] addr,
   input wire logic [7:0] dq_in,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic reset_n,
   output logic [7:0] dq_out,
   output logic ry_pd
);
   logic [7:0] mem [16];
   logic [7:0] pol, val, last;
   logic tog, ers;
   int mode, step, gen, resets;
   initial begin
      foreach (mem[i]) mem[i] = 8'hFF;
      {mode, step, gen, resets, tog, ers, pol, last} = '0;
   end
   // Busy in mode 2 ends after a delay unless a hardware reset bumped the generation.
   task automatic start(input int dur, input int m);
      mode = m;
      gen++;
      fork
         begin
            automatic int g0 = gen;
            #dur;
            if (gen == g0 && mode == 2) mode = 0;
         end
      join_none
   endtask
   // Commands are latched at the rising write edge with the chip selected.
   always @(posedge we_n) if (!ce_n && oe_n && reset_n) begin
      if (mode == 2) step = 0;
      else if (step == 3) begin
         pol = dq_in;
         ers = 0;
         step = 0;
         if (addr[3:0] == 4'hE) start(0, 3);
         else if (addr[3:0] == 4'hF) start(500, 2);
         else begin
            mem[addr[3:0]] &= dq_in;
            start(BUSY_NS, 2);
         end
      end
      else if (dq_in == 8'hF0) begin mode = 0; step = 0; end
      else case (step)
         0: begin step = dq_in == 8'hAA; if (dq_in == 8'h98) mode = 1; end
         1: step = dq_in == 8'h55 ? 2 : 0;
         2: begin
            step = dq_in == 8'hA0 ? 3 : dq_in == 8'h80 ? 4 : 0;
            if (dq_in == 8'h90) mode = 1;
         end
         4: step = dq_in == 8'hAA ? 5 : 0;
         5: step = dq_in == 8'h55 ? 6 : 0;
         default: begin
            step = 0;
            if (dq_in == 8'h10) begin
               foreach (mem[i]) mem[i] = 8'hFF;
               ers = 1;
               start(2 * BUSY_NS, 2);
            end
         end
      endcase
   end
   // Hardware reset aborts any operation at once.
   always @(negedge reset_n) begin gen++; resets++; mode = 0; step = 0; end
   // Each status read flips the toggle bits; they freeze once ready.
   // Chip enable and output enable may fall in one step, so a combined select avoids a race.
   logic rd_sel;
   assign rd_sel = !ce_n && !oe_n;
   always @(posedge rd_sel) if (mode >= 2) tog = ~tog;
   // Read data path; a released bus shows the inverse of the last byte.
   always @* begin
      if (mode == 1) val = addr[7:0] == 8'h00 ? MAKER_ID : addr[7:0] == 8'h02 ? DEV_ID :
         8'h00;
      else if (mode >= 2) val = {~pol[7] & ~ers, tog, mode == 3, 2'b00, ers & tog, 2'b00};
      else val = mem[addr[3:0]];
      if (!ce_n && !oe_n) begin dq_out = val; last = val; end
      else dq_out = ~last;
   end
   assign ry_pd = mode >= 2;
endmodule
`default_nettype wire

/* test/pfc_ctrl_tb.sv */
// Self-checking bench for the flash controller with a behavioural flash.
`timescale 1ns/1ns
`default_nettype none
module pfc_ctrl_tb;
   import pfc_pkg::*;
   localparam logic [7:0] MAKER_ID = 8'h3C; // Arbitrary value.
   localparam logic [7:0] DEV_ID = 8'h7E; // Arbitrary value.
   logic CLK, NRST, REG_WR, REG_RD, FL_DQ_OE, FL_CE_N, FL_WE_N, FL_OE_N, FL_RESET_N, ry_pd;
   logic [7:0] REG_ADDR, FL_DQ_O, fdq, v;
   logic [31:0] REG_WDATA, REG_RDATA, s;
   logic [21:0] FL_ADDR;
   int fail_count, samples_checked;
   pfc_ctrl #(.READY_WAIT_CYC(4)) DUT (.CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .FL_ADDR(FL_ADDR), .FL_DQ_I(FL_DQ_OE ? FL_DQ_O : fdq), .FL_DQ_O(FL_DQ_O),
      .FL_DQ_OE(FL_DQ_OE), .FL_CE_N(FL_CE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N),
      .FL_RESET_N(FL_RESET_N), .FL_READY_BUSY_N(~ry_pd));
   pfc_flash_model #(.MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) u_flash (.addr(FL_ADDR),
      .dq_in(FL_DQ_O), .ce_n(FL_CE_N), .we_n(FL_WE_N), .oe_n(FL_OE_N),
      .reset_n(FL_RESET_N), .dq_out(fdq), .ry_pd(ry_pd));
   initial begin CLK = 0; forever #25 CLK = ~CLK; end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task summarize;
      if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      REG_ADDR <= a; REG_WDATA <= d; REG_WR <= 1'b1;
      @(posedge CLK);
      REG_WR <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe edge.
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK);
      REG_ADDR <= a; REG_RD <= 1'b1;
      @(posedge CLK);
      REG_RD <= 1'b0;
      #1 d = REG_RDATA;
   endtask
   // Polls status under a bounded count so a stuck busy cannot hang the run.
   task op(input pfc_op_t o, input logic [21:0] a, input logic [7:0] d);
      int n;
      wr(pfc_pkg::REG_ADDR, {10'h0, a}); wr(REG_DATA, {24'h0, d}); wr(REG_CMD, {28'h0, o});
      for (n = 0; n < 500; n++) begin
         rd(REG_STATUS, s);
         if (s[ST_BUSY] === 1'b0) break;
      end
      chk(n < 500, 1, "busy never cleared");
   endtask
   task fread(input logic [21:0] a);
      op(OP_READ, a, 8'h00);
      v = s[ST_RDATA_LSB +: 8];
   endtask
   task t_program;
      op(OP_PROGRAM, 22'h3, 8'h5A); chk(s[ST_FAIL], 0, "program fail");
      fread(22'h3); chk(v, 8'h5A, "programmed byte");
      op(OP_PROGRAM, 22'h3, 8'hF0); fread(22'h3); chk(v, 8'h50, "bits only clear");
      op(OP_PROGRAM, 22'hF, 8'h00); fread(22'hF); chk(v, 8'hFF, "protected byte");
      chk(s[ST_READY], 1, "ready after program");
   endtask
   task t_erase;
      op(OP_CHIP_ERASE, 22'h0, 8'h00); fread(22'h3); chk(v, 8'hFF, "erased");
      op(OP_PROGRAM, 22'h0, 8'h12); fread(22'h0); chk(v, 8'h12, "after erase");
   endtask
   task t_autosel;
      op(OP_AUTOSEL, 22'h0, 8'h00); chk(s[ST_ID_MODE], 1, "id mode flag");
      fread(22'h0); chk(v, MAKER_ID, "maker code");
      fread(22'h2); chk(v, DEV_ID, "device code");
      fread(22'h0); chk(v, MAKER_ID, "repeat read");
      fread(22'h4); chk(v, 8'h00, "protect status");
      op(OP_RESET, 22'h0, 8'h00); fread(22'h0); chk(v, 8'h12, "array after reset");
   endtask
   task t_fail;
      op(OP_PROGRAM, 22'hE, 8'h00); chk(s[ST_FAIL], 1, "time exceeded");
      fread(22'h0); chk(v, 8'h12, "array after fail");
   endtask
   task t_misc;
      pfc_op_t ops [3];
      ops = '{OP_QUERY, OP_SUSPEND, OP_RESUME};
      foreach (ops[i]) begin
         op(ops[i], 22'h0, 8'h00); op(OP_RESET, 22'h0, 8'h00);
         fread(22'h0); chk(v, 8'h12, "single command");
      end
      op(OP_HW_RESET, 22'h0, 8'h00); chk(u_flash.resets, 1, "reset pulse");
      fread(22'h0); chk(v, 8'h12, "array after reset pin");
      rd(8'h10, s); chk(s, 32'h0, "unmapped read");
      // Readback proves each offset reaches its own register and the data write leaves the address alone.
      wr(pfc_pkg::REG_ADDR, 32'h2A5); wr(REG_DATA, 32'hC3);
      rd(pfc_pkg::REG_ADDR, s); chk(s, 32'h2A5, "address readback");
      rd(REG_DATA, s); chk(s, 32'hC3, "data readback");
   endtask
   initial begin
      #3000000;
      fail_count++;
      summarize();
   end
   initial begin
      {NRST, REG_WR, REG_RD, REG_ADDR, REG_WDATA, fail_count, samples_checked} = '0;
      repeat (12) @(posedge CLK);
      NRST <= 1'b1;
      repeat (3) @(posedge CLK);
      t_program();
      t_erase();
      t_autosel();
      t_fail();
      t_misc();
      summarize();
   end
endmodule
`default_nettype wire
